// *** common/cac_pkg.sv ***
// Package: constants, register map and mode types of the counter array
package cac_pkg;
    localparam int NUM_MODULES = 6;
    localparam int CNT_W = 16;
    localparam int BYTE_W = 8;
    localparam int TB_W = 3;
    // Register addresses on the special function register port
    localparam logic [7:0] ADDR_COUNT_LOW = 8'h00;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'h01;
    localparam logic [7:0] ADDR_ARRAY_MODE = 8'h02;
    localparam logic [7:0] ADDR_ARRAY_CONTROL = 8'h03;
    localparam logic [7:0] ADDR_MODULE_MODE_BASE = 8'h10;
    localparam logic [7:0] ADDR_CC_LOW_BASE = 8'h20;
    localparam logic [7:0] ADDR_CC_HIGH_BASE = 8'h30;
    // Array mode register fields
    localparam int MD_IDLE_STOP_BIT = 7;
    localparam int MD_TB_LSB = 1;
    localparam int MD_OVF_IRQ_EN_BIT = 0;
    // Array control register fields
    localparam int CN_OVF_FLAG_BIT = 7;
    localparam int CN_RUN_BIT = 6;
    // Module mode register fields
    localparam int MM_WIDE_PWM_BIT = 7;
    localparam int MM_CMP_EN_BIT = 6;
    localparam int MM_RISE_BIT = 5;
    localparam int MM_FALL_BIT = 4;
    localparam int MM_MATCH_BIT = 3;
    localparam int MM_TOGGLE_BIT = 2;
    localparam int MM_PWM_BIT = 1;
    localparam int MM_IRQ_EN_BIT = 0;
    // Reset values and counter maximum
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    // Timebase codes
    localparam logic [2:0] TB_DIV12 = 3'h0;
    localparam logic [2:0] TB_DIV4 = 3'h1;
    localparam logic [2:0] TB_T0_OVF = 3'h2;
    localparam logic [2:0] TB_EXT_FALL = 3'h3;
    localparam logic [2:0] TB_SYSCLK = 3'h4;
    localparam logic [2:0] TB_XOSC8 = 3'h5;
    // Timing counts
    localparam int DIV12_COUNT = 12;
    localparam int DIV4_COUNT = 4;
    localparam int XOSC_DIV = 8;
    localparam int MIN_LEVEL_CYCLES = 2;
    localparam int ECI_MIN_FALL_CYCLES = 4;
    // Decoded mode of one module
    typedef enum logic [2:0] {
        CAC_MODE_NONE,
        CAC_MODE_CAPTURE,
        CAC_MODE_SW_TIMER,
        CAC_MODE_HS_OUT,
        CAC_MODE_FREQ_OUT,
        CAC_MODE_PWM8,
        CAC_MODE_WIDE_PULSE_SELECT
    } cac_mode_t;
endpackage : cac_pkg

// *** common/cac_if.sv ***
// Interface: register port, strobes and pins between CPU side and counter array
interface cac_if (
    input wire logic mclk,
    input wire logic rst_n
);
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr_en;
    logic rd_en;
    logic [7:0] rdata;
    logic idle;
    logic t0_overflow;
    logic external_count_input;
    logic xosc_clk;
    logic [5:0] module_io_line;
    logic irq;

    modport device (
        input mclk, rst_n, addr, wdata, wr_en, rd_en, idle, t0_overflow,
        input external_count_input, xosc_clk, module_io_line,
        output rdata, irq
    );
    modport host (
        input mclk, rst_n, rdata, irq,
        output addr, wdata, wr_en, rd_en, idle, t0_overflow,
        output external_count_input, xosc_clk, module_io_line
    );
endinterface : cac_if

// *** verilog/cac_array.sv ***
// Counter array device end: counter, timebase, capture modules, registers
// What this block does
// - One 16-bit counter as two bytes
// - Low read latches high byte snapshot
// - Reads never disturb counting
// - Timebase select picks div12/div4/t0/ext/sysclk
// - Code 101 counts external oscillator div 8
// - External count falls at most every four clocks
// - Wrap from ffff sets overflow flag
// - Overflow interrupt only when enabled
// - Overflow flag cleared only by software
// - Software enables global and array interrupts
// - Idle stop bit halts counting in idle
// - Six modules, 16-bit registers, shared counter
// - Capture edge select from rise/fall enables
// - Decode timer, high-speed and frequency modes
// - Decode 8-bit and 16-bit PWM modes
// - Module flag interrupts only when enabled
// - Capture loads counter into module register
// - Capture sets module event flag
// - Module flag cleared only by software
// - Levels need two stable clocks
// - Low write clears, high write sets comparator
module cac_array
    import cac_pkg::*;
(
    cac_if.device bus,
    output cac_pkg::cac_mode_t mode_out [cac_pkg::NUM_MODULES]
);
    import cac_pkg::*;

    logic [15:0] count_r;
    logic [7:0] snap_high_r;
    logic [7:0] array_mode_r;
    logic run_r;
    logic ovf_flag_r;
    logic [5:0] evt_flag_r;
    logic [7:0] mmode_r [NUM_MODULES];
    logic [15:0] cc_r [NUM_MODULES];
    logic [3:0] div_cnt_r;
    logic [2:0] eci_sync_r;
    logic [2:0] xosc_sync_r;
    logic [2:0] xdiv_r;
    logic xdiv_tog_r;
    logic eci_lvl_r;
    logic [7:0] rdata_r;
    logic tick;
    logic count_en;
    logic wrap;
    logic [5:0] cap_evt;
    logic [2:0] tb_sel;

    assign tb_sel = array_mode_r[MD_TB_LSB +: TB_W];

    // Free divider for the twelve and four rates; one pulse per period
    always_ff @(posedge bus.mclk) begin
        if (!bus.rst_n) begin
            div_cnt_r <= 4'h0;
        end else if (div_cnt_r == 4'(DIV12_COUNT - 1)) begin
            div_cnt_r <= 4'h0;
        end else begin
            div_cnt_r <= div_cnt_r + 4'h1;
        end
    end

    // Three-stage samplers; stages 2 and 3 agreeing gives a clean edge
    always_ff @(posedge bus.mclk) begin
        if (!bus.rst_n) begin
            eci_sync_r <= 3'h7;
            eci_lvl_r <= 1'b1;
        end else begin
            eci_sync_r <= {eci_sync_r[1:0], bus.external_count_input};
            if (eci_sync_r[1] == eci_sync_r[2]) eci_lvl_r <= eci_sync_r[2];
        end
    end

    // Oscillator divided by eight on its own edges would need a second
    // clock; instead sample it here, valid while it is under half mclk
    always_ff @(posedge bus.mclk) begin
        if (!bus.rst_n) begin
            xosc_sync_r <= 3'h0;
            xdiv_r <= 3'h0;
            xdiv_tog_r <= 1'b0;
        end else begin
            xosc_sync_r <= {xosc_sync_r[1:0], bus.xosc_clk};
            if (xosc_sync_r[1] && !xosc_sync_r[2]) begin
                xdiv_r <= xdiv_r + 3'h1;
                if (xdiv_r == 3'(XOSC_DIV - 1)) begin
                    xdiv_tog_r <= 1'b1;
                end else begin
                    xdiv_tog_r <= 1'b0;
                end
            end else begin
                xdiv_tog_r <= 1'b0;
            end
        end
    end

    // Timebase select
    always_comb begin
        case (tb_sel)
            TB_DIV12: tick = (div_cnt_r == 4'h0);
            TB_DIV4: tick = (div_cnt_r[1:0] == 2'h0);
            TB_T0_OVF: tick = bus.t0_overflow;
            TB_EXT_FALL: tick = eci_lvl_r && !eci_sync_r[1] && !eci_sync_r[2];
            TB_SYSCLK: tick = 1'b1;
            TB_XOSC8: tick = xdiv_tog_r;
            default: tick = 1'b0;
        endcase
    end

    // Idle halts counting only when the idle stop bit is set
    assign count_en = run_r && tick && !(bus.idle && array_mode_r[MD_IDLE_STOP_BIT]);
    assign wrap = count_en && (count_r == COUNT_MAX);

    // Counter; bus reads do not touch it
    always_ff @(posedge bus.mclk) begin
        if (!bus.rst_n) begin
            count_r <= RST_COUNT;
        end else if (bus.wr_en && bus.addr == ADDR_COUNT_LOW) begin
            count_r[7:0] <= bus.wdata;
        end else if (bus.wr_en && bus.addr == ADDR_COUNT_HIGH) begin
            count_r[15:8] <= bus.wdata;
        end else if (count_en) begin
            count_r <= count_r + 16'h0001;
        end
    end

    // Snapshot of the high byte taken on a low byte read
    always_ff @(posedge bus.mclk) begin
        if (!bus.rst_n) begin
            snap_high_r <= RST_BYTE;
        end else if (bus.rd_en && bus.addr == ADDR_COUNT_LOW) begin
            snap_high_r <= count_r[15:8];
        end
    end

    // Per-module line filter and mode decode
    genvar g;
    generate
        for (g = 0; g < NUM_MODULES; g++) begin : g_mod
            logic [2:0] sync_r;
            logic lvl_r;
            logic rise;
            logic fall;
            always_ff @(posedge bus.mclk) begin
                if (!bus.rst_n) begin
                    sync_r <= 3'h0;
                    lvl_r <= 1'b0;
                end else begin
                    sync_r <= {sync_r[1:0], bus.module_io_line[g]};
                    // Level accepted only after two agreeing samples
                    if (sync_r[1] == sync_r[2]) begin
                        lvl_r <= sync_r[2];
                    end
                end
            end
            assign rise = sync_r[1] && sync_r[2] && !lvl_r;
            assign fall = !sync_r[1] && !sync_r[2] && lvl_r;
            // Capture mode needs match, toggle and pwm clear
            assign cap_evt[g] = !mmode_r[g][MM_MATCH_BIT] && !mmode_r[g][MM_TOGGLE_BIT]
                && !mmode_r[g][MM_PWM_BIT]
                && ((mmode_r[g][MM_RISE_BIT] && rise)
                || (mmode_r[g][MM_FALL_BIT] && fall));
            always_comb begin
                logic [7:0] m;
                m = mmode_r[g];
                if (cap_evt[g] || (!m[MM_MATCH_BIT] && !m[MM_TOGGLE_BIT] && !m[MM_PWM_BIT]
                    && (m[MM_RISE_BIT] || m[MM_FALL_BIT]))) begin
                    mode_out[g] = CAC_MODE_CAPTURE;
                end else if (m[MM_CMP_EN_BIT] && m[MM_MATCH_BIT] && !m[MM_PWM_BIT]) begin
                    mode_out[g] = m[MM_TOGGLE_BIT] ? CAC_MODE_HS_OUT
                        : CAC_MODE_SW_TIMER;
                end else if (m[MM_CMP_EN_BIT] && m[MM_TOGGLE_BIT] && m[MM_PWM_BIT]
                    && !m[MM_MATCH_BIT]) begin
                    mode_out[g] = CAC_MODE_FREQ_OUT;
                end else if (m[MM_CMP_EN_BIT] && m[MM_PWM_BIT] && !m[MM_MATCH_BIT]
                    && !m[MM_TOGGLE_BIT] && !m[MM_RISE_BIT] && !m[MM_FALL_BIT]) begin
                    mode_out[g] = m[MM_WIDE_PWM_BIT] ? CAC_MODE_WIDE_PULSE_SELECT
                        : CAC_MODE_PWM8;
                end else begin
                    mode_out[g] = CAC_MODE_NONE;
                end
            end
        end
    endgenerate

    // Module mode and capture registers; capture beats a same-cycle write
    always_ff @(posedge bus.mclk) begin
        if (!bus.rst_n) begin
            for (int i = 0; i < NUM_MODULES; i++) begin
                mmode_r[i] <= RST_BYTE;
                cc_r[i] <= RST_COUNT;
            end
        end else begin
            for (int i = 0; i < NUM_MODULES; i++) begin
                if (bus.wr_en && bus.addr == ADDR_MODULE_MODE_BASE + 8'(i)) begin
                    mmode_r[i] <= bus.wdata;
                end else if (bus.wr_en && bus.addr == ADDR_CC_LOW_BASE + 8'(i)) begin
                    mmode_r[i][MM_CMP_EN_BIT] <= 1'b0;
                end else if (bus.wr_en && bus.addr == ADDR_CC_HIGH_BASE + 8'(i)) begin
                    mmode_r[i][MM_CMP_EN_BIT] <= 1'b1;
                end
                if (cap_evt[i]) begin
                    cc_r[i] <= count_r;
                end else if (bus.wr_en && bus.addr == ADDR_CC_LOW_BASE + 8'(i)) begin
                    cc_r[i][7:0] <= bus.wdata;
                end else if (bus.wr_en && bus.addr == ADDR_CC_HIGH_BASE + 8'(i)) begin
                    cc_r[i][15:8] <= bus.wdata;
                end
            end
        end
    end

    // Array mode and run bit; flags set wins over software clear
    always_ff @(posedge bus.mclk) begin
        if (!bus.rst_n) begin
            array_mode_r <= RST_BYTE;
            run_r <= 1'b0;
            ovf_flag_r <= 1'b0;
            evt_flag_r <= 6'h00;
        end else begin
            if (bus.wr_en && bus.addr == ADDR_ARRAY_MODE) begin
                array_mode_r <= bus.wdata;
            end
            if (bus.wr_en && bus.addr == ADDR_ARRAY_CONTROL) begin
                run_r <= bus.wdata[CN_RUN_BIT];
                ovf_flag_r <= wrap | bus.wdata[CN_OVF_FLAG_BIT];
                evt_flag_r <= cap_evt | bus.wdata[5:0];
            end else begin
                ovf_flag_r <= ovf_flag_r | wrap;
                evt_flag_r <= evt_flag_r | cap_evt;
            end
        end
    end

    // Read data
    always_ff @(posedge bus.mclk) begin
        if (!bus.rst_n) begin
            rdata_r <= RST_BYTE;
        end else if (bus.rd_en) begin
            rdata_r <= RST_BYTE;
            if (bus.addr == ADDR_COUNT_LOW) rdata_r <= count_r[7:0];
            if (bus.addr == ADDR_COUNT_HIGH) rdata_r <= snap_high_r;
            if (bus.addr == ADDR_ARRAY_MODE) rdata_r <= array_mode_r;
            if (bus.addr == ADDR_ARRAY_CONTROL) rdata_r <= {ovf_flag_r, run_r, evt_flag_r};
            for (int i = 0; i < NUM_MODULES; i++) begin
                if (bus.addr == ADDR_MODULE_MODE_BASE + 8'(i)) rdata_r <= mmode_r[i];
                if (bus.addr == ADDR_CC_LOW_BASE + 8'(i)) rdata_r <= cc_r[i][7:0];
                if (bus.addr == ADDR_CC_HIGH_BASE + 8'(i)) rdata_r <= cc_r[i][15:8];
            end
        end
    end
    assign bus.rdata = rdata_r;

    // One request line; global gating is the CPU's business
    always_comb begin
        logic any_mod;
        any_mod = 1'b0;
        for (int i = 0; i < NUM_MODULES; i++) begin
            any_mod = any_mod | (evt_flag_r[i] & mmode_r[i][MM_IRQ_EN_BIT]);
        end
        bus.irq = any_mod | (ovf_flag_r & array_mode_r[MD_OVF_IRQ_EN_BIT]);
    end
endmodule : cac_array

// *** verilog/cac_host.sv ***
// CPU side end: drives the register port and pins from a simple user port
module cac_host
    import cac_pkg::*;
(
    cac_if.host bus,
    input wire logic req_wr,
    input wire logic req_rd,
    input wire logic [7:0] req_addr,
    input wire logic [7:0] req_wdata,
    output logic [7:0] rsp_rdata,
    output logic rsp_valid,
    input wire logic cpu_idle,
    input wire logic timer0_ovf,
    input wire logic ext_count,
    input wire logic ext_osc,
    input wire logic [5:0] io_lines,
    input wire logic global_irq_en,
    input wire logic array_irq_en,
    output logic cpu_irq
);
    import cac_pkg::*;

    logic rd_pend_r;
    logic [7:0] rdata_r;

    // One register access per cycle; write wins if both asked
    assign bus.wr_en = req_wr;
    assign bus.rd_en = req_rd && !req_wr;
    assign bus.addr = req_addr;
    assign bus.wdata = req_wdata;
    assign bus.idle = cpu_idle;
    assign bus.t0_overflow = timer0_ovf;
    assign bus.external_count_input = ext_count;
    assign bus.xosc_clk = ext_osc;
    assign bus.module_io_line = io_lines;

    // Read answer valid one cycle after the read, carrying the device's registered data straight through
    always_ff @(posedge bus.mclk) begin
        if (!bus.rst_n) begin
            rd_pend_r <= 1'b0;
        end else begin
            rd_pend_r <= bus.rd_en;
        end
    end
    assign rsp_valid = rd_pend_r;
    assign rsp_rdata = bus.rdata;

    // Both enables gate the array request
    assign cpu_irq = bus.irq && global_irq_en && array_irq_en;
endmodule : cac_host

// *** verif/cac_asserts.sv ***
// Checker: register port and interrupt relations seen on the interface
module cac_asserts
    import cac_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] rdata,
    input wire logic irq
);
    import cac_pkg::*;
    logic ovf_en_r;
    logic [5:0] mod_en_r;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Shadow of the interrupt enables, so irq can be judged without the body
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ovf_en_r <= 1'b0;
            mod_en_r <= 6'h00;
        end else if (wr_en && addr == ADDR_ARRAY_MODE) begin
            ovf_en_r <= wdata[MD_OVF_IRQ_EN_BIT];
        end else if (wr_en && addr[7:4] == 4'h1 && addr[3:0] < 4'h6) begin
            mod_en_r[addr[2:0]] <= wdata[MM_IRQ_EN_BIT];
        end
    end
    property p_irq_quiet;
        (!ovf_en_r && mod_en_r == 6'h00) |-> !irq;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("irq without enable");
    property p_irq_sticky;
        irq && !wr_en |=> irq;
    endproperty
    a_irq_sticky: assert property (p_irq_sticky) else $error("irq dropped by itself");
    property p_rd_hold;
        !rd_en |=> $stable(rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_cmp_clr;
        rd_en && !wr_en && addr[7:4] == 4'h1 && $past(wr_en) && $past(addr) == addr + 8'h10
            |=> !rdata[MM_CMP_EN_BIT];
    endproperty
    a_cmp_clr: assert property (p_cmp_clr) else $error("low write kept comparator");
    property p_cmp_set;
        rd_en && !wr_en && addr[7:4] == 4'h1 && $past(wr_en) && $past(addr) == addr + 8'h20
            |=> rdata[MM_CMP_EN_BIT];
    endproperty
    a_cmp_set: assert property (p_cmp_set) else $error("high write left comparator");
    property p_mode_rb;
        wr_en && addr == ADDR_ARRAY_MODE ##1 rd_en && !wr_en && addr == ADDR_ARRAY_MODE
            |=> (rdata & 8'h8f) == ($past(wdata, 2) & 8'h8f);
    endproperty
    a_mode_rb: assert property (p_mode_rb) else $error("array mode readback");
    property p_unmapped;
        rd_en && !wr_en && addr == 8'h04 |=> rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_rst_irq;
        $rose(rst_n) |-> !irq;
    endproperty
    a_rst_irq: assert property (p_rst_irq) else $error("irq high after reset");
    // Main scenarios reached
    c_high_rd: cover property (rd_en && addr == ADDR_COUNT_HIGH);
    c_irq: cover property (irq);
    c_cc_wr: cover property (wr_en && addr[7:4] == 4'h2);
endmodule : cac_asserts

// *** verif/tb.sv ***
// Testbench: host and counter array joined by the interface, random and corner cases
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import cac_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic req_wr = 1'b0, req_rd = 1'b0, cpu_idle = 1'b0, t0 = 1'b0, ext = 1'b1, osc = 1'b0;
    logic gie = 1'b1, aie = 1'b1, rsp_valid, cpu_irq;
    logic [7:0] req_addr = 8'h00, req_wdata = 8'h00, rsp_rdata, last_rd, d, lo;
    logic [5:0] io = 6'h00;
    logic [15:0] v, e;
    logic [2:0] cfg;
    cac_mode_t mode_out [NUM_MODULES];
    int errors = 0, n_compared = 0, seed = 32'h124f, cyc = 0, rd_cnt = 0, i, n;
    logic [7:0] ra [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h10, 8'h20, 8'h30, 8'h04};
    logic [7:0] mv [7] = '{8'h00, 8'h20, 8'h48, 8'h4c, 8'h46, 8'h42, 8'hc2};
    cac_mode_t me [7] = '{CAC_MODE_NONE, CAC_MODE_CAPTURE, CAC_MODE_SW_TIMER, CAC_MODE_HS_OUT,
        CAC_MODE_FREQ_OUT, CAC_MODE_PWM8, CAC_MODE_WIDE_PULSE_SELECT};
    cac_if bus_if (.mclk(mclk), .rst_n(rst_n));
    cac_host cac_host_inst (.bus(bus_if), .req_wr(req_wr), .req_rd(req_rd), .req_addr(req_addr),
        .req_wdata(req_wdata), .rsp_rdata(rsp_rdata), .rsp_valid(rsp_valid),
        .cpu_idle(cpu_idle), .timer0_ovf(t0), .ext_count(ext), .ext_osc(osc), .io_lines(io),
        .global_irq_en(gie), .array_irq_en(aie), .cpu_irq(cpu_irq));
    cac_array cac_array_inst (.bus(bus_if), .mode_out(mode_out));
    cac_asserts cac_asserts_inst (.mclk(mclk), .rst_n(rst_n), .addr(bus_if.addr),
        .wdata(bus_if.wdata), .wr_en(bus_if.wr_en), .rd_en(bus_if.rd_en),
        .rdata(bus_if.rdata), .irq(bus_if.irq));
    // Clocks: oscillator kept slower than half the system clock and out of phase
    initial forever #25 mclk = ~mclk;
    initial forever #66 osc = ~osc;
    // Timer 0 pulse every 10 cycles; count pin falls every 8, inside the 4-cycle limit
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        t0 <= (cyc % 10 == 9);
        if (cyc % 4 == 0) ext <= ~ext;
        if (rsp_valid === 1'b1) begin
            last_rd <= rsp_rdata;
            rd_cnt <= rd_cnt + 1;
        end
    end
    task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] wd);
        @(posedge mclk);
        req_wr <= w;
        req_rd <= r;
        req_addr <= a;
        req_wdata <= wd;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [7:0] wd);
        bus(1'b1, 1'b0, a, wd);
    endtask : wr
    task automatic idle(input int k);
        repeat (k) bus(1'b0, 1'b0, 8'h00, 8'h00);
        #1;
    endtask : idle
    // Read waits for the host's answer pulse under a bound
    task automatic rd(input logic [7:0] a);
        int k;
        k = rd_cnt;
        bus(1'b0, 1'b1, a, 8'h00);
        bus(1'b0, 1'b0, a, 8'h00);
        for (int j = 0; j < 6 && rd_cnt == k; j++) @(posedge mclk);
        #1;
        d = last_rd;
        chk("read_answer", 16'(rd_cnt != k), 16'h1);
    endtask : rd
    task automatic rdcnt;
        rd(ADDR_COUNT_LOW);
        lo = d;
        rd(ADDR_COUNT_HIGH);
        v = {d, lo};
    endtask : rdcnt
    task automatic setcnt(input logic [15:0] c);
        wr(ADDR_COUNT_LOW, c[7:0]);
        wr(ADDR_COUNT_HIGH, c[15:8]);
    endtask : setcnt
    task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] x);
        n_compared++;
        if (s !== x) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, x, s);
        end
    endtask : chk
    // Ticks expected in nc cycles for each timebase code
    function automatic int exp_ticks(input int c, input int nc);
        case (c)
            0: return nc / DIV12_COUNT;
            1: return nc / DIV4_COUNT;
            2: return nc / 10;
            3: return nc / 8;
            4: return nc;
            default: return nc * 50 / (132 * XOSC_DIV);
        endcase
    endfunction : exp_ticks
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish
    // Watchdog sized well above the expected run
    initial begin
        #(20000 * 50);
        errors++;
        tally_and_finish();
    end
    initial begin
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        wr(8'h04, 8'hff);
        for (i = 0; i < 8; i++) begin
            rd(ra[i]);
            chk("reset_value", d, 8'h00);
        end
        $display("test reset done");
        for (i = 0; i < 7; i++) begin
            wr(ADDR_MODULE_MODE_BASE + 8'h02, mv[i]);
            rd(ADDR_MODULE_MODE_BASE + 8'h02);
            chk("mode_decode", mode_out[2], me[i]);
            chk("mode_reg", d, mv[i]);
        end
        wr(ADDR_CC_LOW_BASE + 8'h02, 8'h5a);
        rd(ADDR_MODULE_MODE_BASE + 8'h02);
        chk("cmp_after_low", d[MM_CMP_EN_BIT], 1'b0);
        wr(ADDR_CC_HIGH_BASE + 8'h02, 8'ha5);
        rd(ADDR_MODULE_MODE_BASE + 8'h02);
        chk("cmp_after_high", d[MM_CMP_EN_BIT], 1'b1);
        wr(ADDR_MODULE_MODE_BASE + 8'h02, 8'h00);
        $display("test mode done");
        // Run each timebase for 240 cycles between run-bit writes
        for (i = 0; i < 6; i++) begin
            setcnt(16'h0000);
            wr(ADDR_ARRAY_MODE, {4'h0, 3'(i), 1'b0});
            rd(ADDR_ARRAY_MODE);
            chk("mode_readback", d, {4'h0, 3'(i), 1'b0});
            wr(ADDR_ARRAY_CONTROL, 8'h40);
            idle(239);
            wr(ADDR_ARRAY_CONTROL, 8'h00);
            rdcnt();
            e = 16'(exp_ticks(i, 240));
            if (i == 4) chk("sysclk_rate", v, e);
            else chk("timebase_rate", v + 16'h2 >= e && v <= e + 16'h2, 1'b1);
        end
        $display("test timebase done");
        wr(ADDR_ARRAY_MODE, {4'h0, TB_SYSCLK, 1'b0});
        setcnt(16'h00f0);
        wr(ADDR_ARRAY_CONTROL, 8'h40);
        rd(ADDR_COUNT_LOW);
        chk("low_live", d >= 8'hf0, 1'b1);
        idle(20);
        rd(ADDR_COUNT_HIGH);
        chk("snapshot", d, 8'h00);
        rdcnt();
        chk("keeps_counting", v > 16'h0100 && v < 16'h0200, 1'b1);
        $display("test snapshot done");
        setcnt(16'hfff0);
        idle(30);
        rd(ADDR_ARRAY_CONTROL);
        chk("ovf_flag", d[CN_OVF_FLAG_BIT], 1'b1);
        chk("irq_masked", cpu_irq, 1'b0);
        wr(ADDR_ARRAY_MODE, {4'h0, TB_SYSCLK, 1'b1});
        idle(40);
        chk("irq_held", cpu_irq, 1'b1);
        @(posedge mclk) gie <= 1'b0;
        idle(1);
        chk("irq_global_off", cpu_irq, 1'b0);
        @(posedge mclk) gie <= 1'b1;
        aie <= 1'b0;
        idle(1);
        chk("irq_array_off", cpu_irq, 1'b0);
        @(posedge mclk) aie <= 1'b1;
        idle(1);
        chk("irq_both_on", cpu_irq, 1'b1);
        wr(ADDR_ARRAY_CONTROL, 8'h40);
        idle(1);
        chk("irq_cleared", cpu_irq, 1'b0);
        $display("test overflow done");
        @(posedge mclk) cpu_idle <= 1'b1;
        wr(ADDR_ARRAY_MODE, {1'b1, 3'h0, TB_SYSCLK, 1'b0});
        rd(ADDR_COUNT_LOW);
        lo = d;
        idle(5);
        rd(ADDR_COUNT_LOW);
        chk("idle_halt", d, lo);
        wr(ADDR_ARRAY_MODE, {4'h0, TB_SYSCLK, 1'b0});
        rd(ADDR_COUNT_LOW);
        lo = d;
        idle(5);
        rd(ADDR_COUNT_LOW);
        chk("idle_run", d != lo, 1'b1);
        @(posedge mclk) cpu_idle <= 1'b0;
        $display("test idle done");
        // Capture with the counter stopped at a random value
        wr(ADDR_ARRAY_CONTROL, 8'h00);
        for (n = 0; n < NUM_MODULES; n++) begin
            cfg = 3'(n % 3 + 1);
            v = 16'($random(seed));
            setcnt(v);
            wr(ADDR_MODULE_MODE_BASE + 8'(n), {2'b00, cfg[0], cfg[1], 3'b000, n[0]});
            @(posedge mclk) io[n] <= 1'b1;
            @(posedge mclk) io[n] <= 1'b0;
            idle(10);
            rd(ADDR_ARRAY_CONTROL);
            chk("glitch_ignored", d[n], 1'b0);
            @(posedge mclk) io[n] <= 1'b1;
            idle(10);
            rd(ADDR_ARRAY_CONTROL);
            chk("rise_flag", d[n], cfg[0]);
            chk("module_irq", cpu_irq, cfg[0] & n[0]);
            wr(ADDR_ARRAY_CONTROL, 8'h00);
            @(posedge mclk) io[n] <= 1'b0;
            idle(10);
            rd(ADDR_ARRAY_CONTROL);
            chk("fall_flag", d[n], cfg[1]);
            rd(ADDR_CC_LOW_BASE + 8'(n));
            lo = d;
            rd(ADDR_CC_HIGH_BASE + 8'(n));
            chk("captured", {d, lo}, v);
            wr(ADDR_ARRAY_CONTROL, 8'h00);
        end
        $display("test capture done");
        tally_and_finish();
    end
endmodule : tb
